// ---- hw/mmod_decoder.sv ----
// Notes on behaviour
// - overlay zero, map pin low: whole program space on chip
// - nonzero program overlay, map pin low: 0x2000-0x3FFF goes external
// - program overlay A13 follows overlay, low 13 bits
// - overlays never saved on mode stack
// - map pin high: no boot, swapped program map
// - data top 32 words are control registers
// - nonzero data overlay, map pin low: 0x0000-0x1FFF external
// - data overlay A13 follows overlay, low 13 bits
// - internal one cycle, external data waits stretch
// - program RAM serves fetch and data together
// - io space eleven bits, upper bits undefined
// - four io regions, own 3-bit waits each
// - byte space: page on data lines, 22 bits
// - reset empties stacks, masks interrupts, clears mode
// - boot once bus request drops, unless map high
// - warm reset: no stabilisation delay inserted
//
// Register access over AXI4-Lite and the placing of the registers are this design's own decisions.
module mmod_decoder #(
  parameter int STACK_DEPTH = 12,
  parameter int IMASK_W     = 10,
  parameter int MODE_W      = 7
) (
  input  wire logic               clk_sys,
  input  wire logic               rstn,
  input  wire logic [7:0]         s_axi_awaddr,
  input  wire logic               s_axi_awvalid,
  output logic                    s_axi_awready,
  input  wire logic [31:0]        s_axi_wdata,
  input  wire logic [3:0]         s_axi_wstrb,
  input  wire logic               s_axi_wvalid,
  output logic                    s_axi_wready,
  output logic [1:0]              s_axi_bresp,
  output logic                    s_axi_bvalid,
  input  wire logic               s_axi_bready,
  input  wire logic [7:0]         s_axi_araddr,
  input  wire logic               s_axi_arvalid,
  output logic                    s_axi_arready,
  output logic [31:0]             s_axi_rdata,
  output logic [1:0]              s_axi_rresp,
  output logic                    s_axi_rvalid,
  input  wire logic               s_axi_rready,
  input  wire logic               map_select_pin,
  input  wire logic               bus_request,
  input  wire logic               boot_done,
  output logic                    boot_active,
  output logic                    core_run,
  input  wire logic               acc_req,
  input  wire logic [1:0]         acc_space,
  input  wire logic [13:0]        acc_addr,
  input  wire logic [7:0]         byte_page,
  output logic                    acc_ack,
  output logic                    int_sel,
  output logic                    ctrl_reg_sel,
  output logic [3:0]              ext_sel,
  output logic [13:0]             ext_addr,
  output logic [7:0]              ext_addr_hi,
  input  wire logic               fetch_req,
  input  wire logic [13:0]        fetch_addr,
  output logic                    fetch_ack,
  output logic                    fetch_ext,
  input  wire logic               irq_entry,
  input  wire logic               irq_exit,
  output logic [MODE_W-1:0]       mode_status_word,
  output logic [IMASK_W-1:0]      imask
);
  localparam int SP_W = $clog2(STACK_DEPTH + 1);

  logic                 rst_q1, rst_n, map_q;
  logic [1:0]           program_overlay_select, data_overlay_select;
  logic [2:0]           data_wait_setting, byte_wait_setting, wait_cnt, next_waits;
  logic [2:0]           io_region_wait_setting [4];
  logic [MODE_W-1:0]    mode_stack [STACK_DEPTH];
  logic [SP_W-1:0]      stack_ptr;
  mmod_pkg::mmod_boot_t boot_state;
  logic                 aw_held, w_held, wr_fire, wr_hit, rd_hit, busy;
  logic                 next_ext, next_a13;
  logic [7:0]           aw_addr;
  logic [31:0]          w_data, rd_word;
  logic [13:0]          next_addr;

  // reset released through two flops; assertion stays asynchronous
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      rst_q1 <= 1'b0;
      rst_n  <= 1'b0;
    end else begin
      rst_q1 <= 1'b1;
      rst_n  <= rst_q1;
    end
  end
  // map pin is a strap, sampled by a clocked process
  always_ff @(posedge clk_sys) begin
    map_q <= map_select_pin;
  end
  // write address and data may arrive in either order
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      aw_held       <= 1'b0;
      w_held        <= 1'b0;
      aw_addr       <= 8'h00;
      w_data        <= 32'h0000_0000;
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= mmod_pkg::RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held       <= 1'b1;
        aw_addr       <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held       <= 1'b1;
        w_data       <= s_axi_wdata;
        s_axi_wready <= 1'b0;
      end
      if (wr_fire) begin
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_hit ? mmod_pkg::RESP_OKAY : mmod_pkg::RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end
  // a write commits once both halves are held and the last answer is gone
  assign wr_fire = aw_held && w_held && !s_axi_bvalid;
  assign wr_hit  = aw_addr == mmod_pkg::REG_OVERLAY || aw_addr == mmod_pkg::REG_WAITS ||
                   aw_addr == mmod_pkg::REG_MODE || aw_addr == mmod_pkg::REG_IMASK;
  // control registers; strobes ignored since every field is narrow
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      program_overlay_select <= mmod_pkg::OVL_INT;
      data_overlay_select    <= mmod_pkg::OVL_INT;
      data_wait_setting      <= 3'h7;
      byte_wait_setting      <= 3'h7;
      imask                  <= '0;
      for (int i = 0; i < 4; i++) begin
        io_region_wait_setting[i] <= 3'h7;
      end
    end else if (wr_fire) begin
      unique case (aw_addr)
        mmod_pkg::REG_OVERLAY: begin
          program_overlay_select <= w_data[mmod_pkg::F_PM_OVL +: 2];
          data_overlay_select    <= w_data[mmod_pkg::F_DM_OVL +: 2];
        end
        mmod_pkg::REG_WAITS: begin
          data_wait_setting <= w_data[mmod_pkg::F_DATA_WAIT_SETTING +: 3];
          byte_wait_setting <= w_data[mmod_pkg::F_BWAIT +: 3];
          for (int i = 0; i < 4; i++) begin
            io_region_wait_setting[i] <= w_data[mmod_pkg::F_IOWAIT + 4 * i +: 3];
          end
        end
        mmod_pkg::REG_IMASK: imask <= w_data[IMASK_W-1:0];
        default: ;
      endcase
    end
  end
  // mode word and its stack; overlay selects never travel with it
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      mode_status_word <= '0;
      stack_ptr        <= '0;
    end else if (wr_fire && aw_addr == mmod_pkg::REG_MODE) begin
      mode_status_word <= w_data[MODE_W-1:0];
    end else if (irq_entry && stack_ptr != SP_W'(STACK_DEPTH)) begin
      mode_stack[stack_ptr] <= mode_status_word;
      stack_ptr             <= stack_ptr + 1'b1;
    end else if (irq_exit && stack_ptr != '0) begin
      mode_status_word <= mode_stack[stack_ptr - 1'b1];
      stack_ptr        <= stack_ptr - 1'b1;
    end
  end
  // register read mux
  always_comb begin
    rd_word = 32'h0000_0000;
    rd_hit  = 1'b1;
    unique case (s_axi_araddr)
      mmod_pkg::REG_OVERLAY: begin
        rd_word[mmod_pkg::F_PM_OVL +: 2] = program_overlay_select;
        rd_word[mmod_pkg::F_DM_OVL +: 2] = data_overlay_select;
      end
      mmod_pkg::REG_WAITS: begin
        rd_word[mmod_pkg::F_DATA_WAIT_SETTING +: 3] = data_wait_setting;
        rd_word[mmod_pkg::F_BWAIT +: 3] = byte_wait_setting;
        for (int i = 0; i < 4; i++) begin
          rd_word[mmod_pkg::F_IOWAIT + 4 * i +: 3] = io_region_wait_setting[i];
        end
      end
      mmod_pkg::REG_MODE:  rd_word[MODE_W-1:0] = mode_status_word;
      mmod_pkg::REG_IMASK: rd_word[IMASK_W-1:0] = imask;
      mmod_pkg::REG_STATUS: begin
        rd_word[mmod_pkg::F_ST_BOOT +: 2]    = boot_state;
        rd_word[mmod_pkg::F_ST_MAP]          = map_q;
        rd_word[mmod_pkg::F_ST_DEPTH +: SP_W] = stack_ptr;
      end
      default: rd_hit = 1'b0;
    endcase
  end
  // read channel answers one cycle after the address is taken
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= mmod_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= rd_word;
      s_axi_rresp   <= rd_hit ? mmod_pkg::RESP_OKAY : mmod_pkg::RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end
  // boot decision after reset release; no clock settling wait
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      boot_state  <= mmod_pkg::BT_CHECK;
      boot_active <= 1'b0;
      core_run    <= 1'b0;
    end else begin
      unique case (boot_state)
        mmod_pkg::BT_CHECK: begin
          if (map_q) begin
            boot_state <= mmod_pkg::BT_RUN;
            core_run   <= 1'b1;
          end else if (!bus_request) begin
            boot_state  <= mmod_pkg::BT_LOAD;
            boot_active <= 1'b1;
          end
        end
        mmod_pkg::BT_LOAD: begin
          if (boot_done) begin
            boot_state  <= mmod_pkg::BT_RUN;
            boot_active <= 1'b0;
            core_run    <= 1'b1;
          end
        end
        mmod_pkg::BT_RUN: ;
      endcase
    end
  end
  // space decode for the data-side access
  always_comb begin
    next_ext   = 1'b0;
    next_a13   = 1'b0;
    next_addr  = {1'b0, acc_addr[mmod_pkg::ADDR_LO_W-1:0]};
    next_waits = data_wait_setting;
    unique case (acc_space)
      mmod_pkg::SP_PM: begin
        if (map_q) begin
          next_ext = !acc_addr[13];
        end else if (program_overlay_select != mmod_pkg::OVL_INT) begin
          next_ext = acc_addr[13];
          next_a13 = program_overlay_select == mmod_pkg::OVL_TWO;
        end
      end
      mmod_pkg::SP_DM: begin
        if (!map_q && data_overlay_select != mmod_pkg::OVL_INT) begin
          next_ext = !acc_addr[13];
          next_a13 = data_overlay_select == mmod_pkg::OVL_TWO;
        end
      end
      mmod_pkg::SP_IO: begin
        next_ext   = 1'b1;
        next_addr  = {3'b000, acc_addr[mmod_pkg::IO_ADDR_W-1:0]};
        next_waits = io_region_wait_setting[acc_addr[10:9]];
      end
      mmod_pkg::SP_BM: begin
        next_ext   = 1'b1;
        next_addr  = acc_addr;
        next_waits = byte_wait_setting;
      end
    endcase
    next_addr[13] = (acc_space == mmod_pkg::SP_PM || acc_space == mmod_pkg::SP_DM) ? next_a13 : next_addr[13];
  end
  // access sequencer: internal answers next cycle, external after waits
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      busy         <= 1'b0;
      wait_cnt     <= 3'h0;
      acc_ack      <= 1'b0;
      int_sel      <= 1'b0;
      ctrl_reg_sel <= 1'b0;
      ext_sel      <= 4'h0;
      ext_addr     <= 14'h0000;
      ext_addr_hi  <= 8'h00;
    end else begin
      acc_ack <= 1'b0;
      if (!busy && acc_req) begin
        busy         <= 1'b1;
        int_sel      <= !next_ext;
        ctrl_reg_sel <= acc_space == mmod_pkg::SP_DM && acc_addr >= mmod_pkg::DM_CTRL_BASE;
        wait_cnt     <= next_ext ? next_waits : 3'h0;
        if (next_ext) begin
          ext_sel[acc_space] <= 1'b1;
          ext_addr           <= next_addr;
          ext_addr_hi        <= acc_space == mmod_pkg::SP_BM ? byte_page : 8'h00;
        end
        if (!next_ext || next_waits == 3'h0) begin
          acc_ack <= 1'b1;
        end
      end else if (busy) begin
        if (acc_ack) begin
          busy    <= 1'b0;
          int_sel <= 1'b0;
          ext_sel <= 4'h0;
          ctrl_reg_sel <= 1'b0;
        end else begin
          wait_cnt <= wait_cnt - 1'b1;
          acc_ack  <= wait_cnt == 3'h1;
        end
      end
    end
  end
  // instruction fetch port runs beside the data access
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      fetch_ack <= 1'b0;
      fetch_ext <= 1'b0;
    end else begin
      fetch_ack <= fetch_req;
      fetch_ext <= fetch_req && (map_q ? !fetch_addr[13]
                   : (program_overlay_select != mmod_pkg::OVL_INT && fetch_addr[13]));
    end
  end

  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  int_one_cycle_a: assert property (!busy && acc_req && !next_ext |=> acc_ack && int_sel)
    else $error("internal access not answered in one cycle");
  pm_overlay_a: assert property (!busy && acc_req && acc_space == mmod_pkg::SP_PM && !map_q &&
      program_overlay_select == mmod_pkg::OVL_TWO && acc_addr[13] |=> ext_sel[0] && ext_addr[13])
    else $error("program overlay two must drive a13 high");
  pm_internal_a: assert property (!busy && acc_req && acc_space == mmod_pkg::SP_PM && !map_q &&
      program_overlay_select == mmod_pkg::OVL_INT |=> int_sel)
    else $error("program access left chip with overlay zero");
  dm_overlay_a: assert property (!busy && acc_req && acc_space == mmod_pkg::SP_DM && !map_q &&
      data_overlay_select == mmod_pkg::OVL_ONE && !acc_addr[13] |=> ext_sel[1] && !ext_addr[13])
    else $error("data overlay one must go external with a13 low");
  map_swap_a: assert property (!busy && acc_req && acc_space == mmod_pkg::SP_PM && map_q
      |=> int_sel == $past(acc_addr[13]))
    else $error("map pin high program map wrong");
  io_addr_a: assert property (!busy && acc_req && acc_space == mmod_pkg::SP_IO
      |=> ext_addr[13:11] == 3'b000 && ext_addr[10:0] == $past(acc_addr[10:0]))
    else $error("io address bits wrong");
  io_wait_a: assert property (!busy && acc_req && acc_space == mmod_pkg::SP_IO &&
      io_region_wait_setting[acc_addr[10:9]] == 3'h3 |=> !acc_ack [*3] ##1 acc_ack)
    else $error("io wait count not honoured");
  boot_map_a: assert property (boot_state == mmod_pkg::BT_CHECK && map_q |=> core_run && !boot_active)
    else $error("map pin high must skip boot");
  boot_hold_a: assert property (boot_state == mmod_pkg::BT_LOAD && !boot_done |=> !core_run)
    else $error("core ran before boot loading ended");
  fetch_dual_a: assert property (fetch_req && !busy && acc_req && !next_ext |=> fetch_ack && acc_ack)
    else $error("fetch and data not served together");
  byte_page_a: assert property (!busy && acc_req && acc_space == mmod_pkg::SP_BM
      |=> ext_addr_hi == $past(byte_page) && ext_sel[3])
    else $error("byte page not driven");
endmodule

// ---- hw/mmod_pkg.sv ----
package mmod_pkg;
  // address spaces seen on the core request port
  localparam logic [1:0] SP_PM = 2'h0;
  localparam logic [1:0] SP_DM = 2'h1;
  localparam logic [1:0] SP_IO = 2'h2;
  localparam logic [1:0] SP_BM = 2'h3;

  // overlay select codes
  localparam logic [1:0] OVL_INT  = 2'h0;
  localparam logic [1:0] OVL_ONE  = 2'h1;
  localparam logic [1:0] OVL_TWO  = 2'h2;

  // data space: 32 control registers start at this bound
  localparam logic [13:0] DM_CTRL_BASE = 14'h3fe0;
  localparam int          ADDR_LO_W    = 13;
  localparam int          IO_ADDR_W    = 11;
  localparam int          WAIT_W       = 3;

  // software register byte addresses
  localparam logic [7:0] REG_OVERLAY = 8'h00;
  localparam logic [7:0] REG_WAITS   = 8'h04;
  localparam logic [7:0] REG_MODE    = 8'h08;
  localparam logic [7:0] REG_IMASK   = 8'h0c;
  localparam logic [7:0] REG_STATUS  = 8'h10;

  // field positions
  localparam int F_PM_OVL   = 0;
  localparam int F_DM_OVL   = 4;
  localparam int F_DATA_WAIT_SETTING    = 0;
  localparam int F_IOWAIT   = 4;
  localparam int F_BWAIT    = 20;
  localparam int F_ST_BOOT  = 0;
  localparam int F_ST_MAP   = 4;
  localparam int F_ST_DEPTH = 8;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {BT_CHECK, BT_LOAD, BT_RUN} mmod_boot_t;
endpackage

// ---- testbench/mmod_ext_model.sv ----
module mmod_ext_model (
  input  wire logic       clk_sys,
  input  wire logic       rstn,
  input  wire logic [3:0] ext_sel,
  output logic      [7:0] ext_count
);
  timeunit 1ns;
  timeprecision 100ps;

  logic prev_any;

  // external memories and peripherals carry no data path here; they only
  // count accesses (rising edges of any select), so an access the decoder wrongly routes out shows up
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      prev_any  <= 1'b0;
      ext_count <= 8'h00;
    end else begin
      prev_any <= |ext_sel;
      if (|ext_sel && !prev_any) begin
        ext_count <= ext_count + 8'h01;
      end
    end
  end
endmodule

// ---- testbench/memory_map_overlay_decoder_bench.sv ----
module memory_map_overlay_decoder_bench;
  timeunit 1ns;
  timeprecision 100ps;

  logic        clk_sys = 1'b0;
  logic        rstn = 1'b0;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, byte_page = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0000_0000;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic        map_select_pin = 1'b0, bus_request = 1'b1, boot_done = 1'b0;
  logic        acc_req = 1'b0, fetch_req = 1'b0, irq_entry = 1'b0, irq_exit = 1'b0;
  logic [1:0]  acc_space = 2'h0;
  logic [13:0] acc_addr = 14'h0000, fetch_addr = 14'h0000;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic        boot_active, core_run, acc_ack, int_sel, ctrl_reg_sel, fetch_ack, fetch_ext;
  logic [3:0]  ext_sel;
  logic [13:0] ext_addr;
  logic [7:0]  ext_addr_hi, ext_count;
  logic [6:0]  mode_status_word;
  logic [9:0]  imask;
  logic [31:0] rd;
  logic [1:0]  rs;
  int          num_errors = 0, cmp_count = 0, i, n;
  int          iol[4] = '{2, 5, 7, 9};

  mmod_decoder dut (
    .clk_sys, .rstn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .map_select_pin, .bus_request,
    .boot_done, .boot_active, .core_run, .acc_req, .acc_space, .acc_addr, .byte_page,
    .acc_ack, .int_sel, .ctrl_reg_sel, .ext_sel, .ext_addr, .ext_addr_hi, .fetch_req,
    .fetch_addr, .fetch_ack, .fetch_ext, .irq_entry, .irq_exit, .mode_status_word, .imask
  );

  mmod_ext_model ext_mem (.clk_sys, .rstn, .ext_sel, .ext_count);

  // 200 MHz system clock
  always #2.5 clk_sys = ~clk_sys;

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task stop_test;
    $display("compares %0d, mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // address and data offered together, each released at its own take
  task wchk(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = mmod_pkg::RESP_OKAY);
    int k;
    @(posedge clk_sys);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (k = 0; k < 64; k++) begin
      @(posedge clk_sys);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid === 1'b1) break;
    end
    s_axi_bready <= 1'b0;
    chk(s_axi_bresp, er);
  endtask

  task rchk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er = mmod_pkg::RESP_OKAY);
    int k;
    @(posedge clk_sys);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (k = 0; k < 64; k++) begin
      @(posedge clk_sys);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid === 1'b1) break;
    end
    rd = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 1'b0;
    chk(rd, e);
    chk(rs, er);
  endtask

  // request held until the ack edge; latency counted in edges from raising it
  task acc(input logic [1:0] sp, input logic [13:0] a, input logic [7:0] pg, input logic ei,
           input logic [3:0] es, input logic [13:0] ea, input logic [13:0] m, input int el);
    int k;
    @(posedge clk_sys);
    acc_space <= sp;
    acc_addr <= a;
    byte_page <= pg;
    acc_req <= 1'b1;
    for (k = 1; k < 64; k++) begin
      @(posedge clk_sys);
      if (acc_ack === 1'b1) break;
    end
    acc_req <= 1'b0;
    chk(k, el);
    chk(int_sel, ei);
    chk(ext_sel, es);
    chk(ext_addr & m, ea);
    chk(ctrl_reg_sel, sp == mmod_pkg::SP_DM && a >= mmod_pkg::DM_CTRL_BASE);
    chk(ext_addr_hi, (sp == mmod_pkg::SP_BM) ? pg : 8'h00);
  endtask

  task fetch(input logic [13:0] a, input logic e);
    @(posedge clk_sys);
    fetch_addr <= a;
    fetch_req <= 1'b1;
    @(posedge clk_sys);
    fetch_req <= 1'b0;
    @(posedge clk_sys);
    chk(fetch_ack, 1'b1);
    chk(fetch_ext, e);
  endtask

  // one-cycle strobe: 0 boot done, 1 interrupt entry, 2 interrupt exit
  task pulse(input int which);
    @(posedge clk_sys);
    if (which == 0) boot_done <= 1'b1;
    if (which == 1) irq_entry <= 1'b1;
    if (which == 2) irq_exit <= 1'b1;
    @(posedge clk_sys);
    boot_done <= 1'b0;
    irq_entry <= 1'b0;
    irq_exit <= 1'b0;
  endtask

  task automatic wait_hi(ref logic s);
    for (int k = 0; k < 64; k++) begin
      if (s === 1'b1) break;
      @(posedge clk_sys);
    end
  endtask

  initial begin
    // reset low from time zero; this model has no oscillator or lock to wait for
    repeat (20) @(posedge clk_sys);
    rstn <= 1'b1;
    // a pending bus request keeps the boot decision open
    repeat (8) @(posedge clk_sys);
    chk(boot_active, 1'b0);
    chk(core_run, 1'b0);
    rchk(mmod_pkg::REG_STATUS, 32'h0000_0000);
    rchk(mmod_pkg::REG_WAITS, 32'h0077_7777);
    rchk(mmod_pkg::REG_OVERLAY, 32'h0000_0000);
    rchk(mmod_pkg::REG_MODE, 32'h0000_0000);
    rchk(mmod_pkg::REG_IMASK, 32'h0000_0000);
    rchk(8'h14, 32'h0000_0000, mmod_pkg::RESP_SLVERR);
    wchk(8'h40, 32'h0000_0001, mmod_pkg::RESP_SLVERR);
    $display("reset values done");
    bus_request <= 1'b0;
    wait_hi(boot_active);
    chk(boot_active, 1'b1);
    chk(core_run, 1'b0);
    rchk(mmod_pkg::REG_STATUS, 32'h0000_0001);
    pulse(0);
    wait_hi(core_run);
    chk(core_run, 1'b1);
    rchk(mmod_pkg::REG_STATUS, 32'h0000_0002);
    $display("boot done");
    acc(mmod_pkg::SP_PM, 14'h2abc, 8'h00, 1'b1, 4'h0, 14'h0000, 14'h0000, 2);
    wchk(mmod_pkg::REG_WAITS, 32'h0017_5303);
    // every nonzero overlay code, program and data side; code 3 drives A13 low, left unchecked
    for (i = 1; i < 4; i++) begin
      wchk(mmod_pkg::REG_OVERLAY, i | (i << 4));
      acc(mmod_pkg::SP_PM, 14'h2abc, 8'h00, 1'b0, 4'h1, (i == 2) ? 14'h2abc : 14'h0abc,
          (i == 3) ? 14'h1fff : 14'h3fff, 5);
      acc(mmod_pkg::SP_PM, 14'h1fff, 8'h00, 1'b1, 4'h0, 14'h0000, 14'h0000, 2);
      acc(mmod_pkg::SP_DM, 14'h1234, 8'h00, 1'b0, 4'h2, (i == 2) ? 14'h3234 : 14'h1234,
          (i == 3) ? 14'h1fff : 14'h3fff, 5);
      acc(mmod_pkg::SP_DM, 14'h2000, 8'h00, 1'b1, 4'h0, 14'h0000, 14'h0000, 2);
    end
    acc(mmod_pkg::SP_DM, 14'h3fe0, 8'h00, 1'b1, 4'h0, 14'h0000, 14'h0000, 2);
    acc(mmod_pkg::SP_DM, 14'h3fdf, 8'h00, 1'b1, 4'h0, 14'h0000, 14'h0000, 2);
    wchk(mmod_pkg::REG_OVERLAY, 32'h0000_0001);
    // internal data access and an external fetch issued in the same cycle
    fork
      acc(mmod_pkg::SP_PM, 14'h0100, 8'h00, 1'b1, 4'h0, 14'h0000, 14'h0000, 2);
      fetch(14'h2000, 1'b1);
    join
    fetch(14'h1000, 1'b0);
    $display("program and data space done");
    // top address of each region, junk in the upper three bits
    for (i = 0; i < 4; i++) begin
      acc(mmod_pkg::SP_IO, {3'h5, i[1:0], 9'h1ff}, 8'h00, 1'b0, 4'h4, {3'h0, i[1:0], 9'h1ff},
          14'h07ff, iol[i]);
    end
    acc(mmod_pkg::SP_BM, 14'h3abc, 8'ha5, 1'b0, 4'h8, 14'h3abc, 14'h3fff, 3);
    $display("io and byte space done");
    wchk(mmod_pkg::REG_OVERLAY, 32'h0000_0011);
    wchk(mmod_pkg::REG_MODE, 32'h0000_0055);
    pulse(1);
    wchk(mmod_pkg::REG_MODE, 32'h0000_000a);
    wchk(mmod_pkg::REG_OVERLAY, 32'h0000_0022);
    pulse(2);
    rchk(mmod_pkg::REG_MODE, 32'h0000_0055);
    chk(mode_status_word, 32'h0000_0055);
    rchk(mmod_pkg::REG_OVERLAY, 32'h0000_0022);
    pulse(1);
    rchk(mmod_pkg::REG_STATUS, 32'h0000_0102);
    wchk(mmod_pkg::REG_IMASK, 32'h0000_03ff);
    rchk(mmod_pkg::REG_IMASK, 32'h0000_03ff);
    $display("mode stack done");
    // warm reset with the map pin high: no boot, no settling wait
    @(posedge clk_sys);
    map_select_pin <= 1'b1;
    rstn <= 1'b0;
    repeat (3) @(posedge clk_sys);
    rstn <= 1'b1;
    for (n = 0; n < 8 && core_run !== 1'b1; n++) begin
      @(posedge clk_sys);
      chk(boot_active, 1'b0);
    end
    chk(core_run, 1'b1);
    rchk(mmod_pkg::REG_STATUS, 32'h0000_0012);
    rchk(mmod_pkg::REG_MODE, 32'h0000_0000);
    rchk(mmod_pkg::REG_IMASK, 32'h0000_0000);
    chk(mode_status_word, 32'h0000_0000);
    chk(imask, 32'h0000_0000);
    wchk(mmod_pkg::REG_OVERLAY, 32'h0000_0011);
    acc(mmod_pkg::SP_PM, 14'h0100, 8'h00, 1'b0, 4'h1, 14'h0100, 14'h1fff, 9);
    acc(mmod_pkg::SP_PM, 14'h2100, 8'h00, 1'b1, 4'h0, 14'h0000, 14'h0000, 2);
    chk(ext_count, 8'h01);
    $display("map pin done");
    stop_test;
  end

  // whole run takes a few hundred cycles
  initial begin
    #100_000;
    num_errors++;
    $display("mismatch at %0t: run did not finish", $time);
    stop_test;
  end
endmodule
